// ---- logic/spc_map.svh ----
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// Register indices on the indexed I/O port
`define SPC_IDX_PINFN     8'h72
`define SPC_IDX_PWRSIG    8'h73
`define SPC_IDX_CSWIDTH   8'h7E
`define SPC_IDX_FLOAT     8'h7F
// Pin function control fields
`define SPC_PF_SYNCSEL    0
`define SPC_PF_BIASSEL    1
`define SPC_PF_G0DATA     2
`define SPC_PF_G0FN_LO    3
`define SPC_PF_G1DATA     5
`define SPC_PF_G1FN_LO    6
// Power signaling fields
`define SPC_PS_HDATA      0
`define SPC_PS_HSEL       1
`define SPC_PS_VDATA      2
`define SPC_PS_VSEL       3
`define SPC_PS_DRVSTBY    4
`define SPC_PS_HCLK       5
`define SPC_PS_VCLK       6
// Composite width fields
`define SPC_CW_ROUND      5
// Float/test fields
`define SPC_FT_BUS        0
`define SPC_FT_MEM        1
`define SPC_FT_TEST_LO    2
`define SPC_FT_TESTEN     6
// Reset values
`define SPC_RST_PINFN     8'h00
`define SPC_RST_PWRSIG    8'h00
`define SPC_RST_CSWIDTH   8'h00
`define SPC_RST_FLOAT     8'h00
// Vertical equalization/serration span in scan lines
`define SPC_VEQ_LINES     3
`endif

// ---- logic/spc_pkg.sv ----
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_FN_NATIVE,
        SPC_FN_COMBINED_SYNC_OUTPUT,
        SPC_FN_GPIN,
        SPC_FN_GPOUT
    } spc_pin_fn_t;
    typedef enum logic [1:0] {
        SPC_CS_IDLE,
        SPC_CS_PULSE
    } spc_cs_state_t;
endpackage : spc_pkg

// ---- logic/spc_combined_sync_output_gen.sv ----
`timescale 1ns/100ps
`include "spc_map.svh"
module spc_combined_sync_output_gen #(
    parameter int WIDTH_BITS = 5
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  crtc_hsync,
    input  wire logic                  crtc_vsync,
    input  wire logic [WIDTH_BITS-1:0] pulse_width,
    input  wire logic                  round_off,
    output logic                       combined_sync_output
);
    import spc_pkg::*;

    typedef struct packed {
        spc_cs_state_t         state;
        logic [WIDTH_BITS:0]   count;
        logic                  hs_prev;
        logic                  out;
    } spc_cs_t;

    spc_cs_t cur;
    spc_cs_t next_cur;

    function automatic logic [WIDTH_BITS:0] eq_width(
        input logic [WIDTH_BITS-1:0] w,
        input logic                  r
    );
        logic [WIDTH_BITS:0] diff;
        diff = {1'b0, w} - {{WIDTH_BITS{1'b0}}, r};
        return (diff >> 1) + 1'b1;
    endfunction : eq_width

    logic hs_rise;
    assign hs_rise = crtc_hsync & ~cur.hs_prev;
    assign combined_sync_output   = cur.out;

    // Outside vertical sync: one pulse of width+1 per line.
    // Inside vertical sync: half-width equalizing pulse, keeps monitor locked.
    always_comb begin
        next_cur         = cur;
        next_cur.hs_prev = crtc_hsync;
        case (cur.state)
            SPC_CS_IDLE: begin
                if (hs_rise) begin
                    next_cur.state = SPC_CS_PULSE;
                    next_cur.out   = 1'b1;
                    next_cur.count = crtc_vsync ? eq_width(pulse_width, round_off)
                                                : {1'b0, pulse_width} + 1'b1;
                end
            end
            SPC_CS_PULSE: begin
                if (cur.count <= 1) begin
                    next_cur.state = SPC_CS_IDLE;
                    next_cur.out   = 1'b0;
                    next_cur.count = '0;
                end else begin
                    next_cur.count = cur.count - 1'b1;
                end
            end
            default: next_cur.state = SPC_CS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    property p_width_normal;
        @(posedge clk) disable iff (!rst_n)
        (cur.state == SPC_CS_IDLE && hs_rise && !crtc_vsync)
            |=> (cur.count == {1'b0, $past(pulse_width)} + 1'b1);
    endproperty
    a_width_normal: assert property (p_width_normal) else $error("combined_sync_output width wrong");

    property p_width_eq;
        @(posedge clk) disable iff (!rst_n)
        (cur.state == SPC_CS_IDLE && hs_rise && crtc_vsync)
            |=> (cur.count == eq_width($past(pulse_width), $past(round_off)));
    endproperty
    a_width_eq: assert property (p_width_eq) else $error("equalizing width wrong");
endmodule : spc_combined_sync_output_gen

// ---- logic/spc_pin_control.sv ----
`timescale 1ns/100ps
`include "spc_map.svh"
module spc_pin_control #(
    parameter int WIDTH_BITS = 5
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_index,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic       crtc_hsync,
    input  wire logic       crtc_vsync,
    input  wire logic       crt_vsync_interval,
    input  wire logic       combined_sync_output_mode,
    input  wire logic       seq_clock,
    input  wire logic       activity_level,
    input  wire logic       bias_enable_level,
    input  wire logic       backlight_level,
    input  wire logic       synth_enabled,
    input  wire logic       act_pin_is_addr,
    input  wire logic       bkl_pin_is_addr,
    input  wire logic       low_power_mode,
    input  wire logic       activity_indicator_pin_in,
    input  wire logic       backlight_enable_pin_in,
    output logic            activity_indicator_pin_out,
    output logic            activity_indicator_pin_oe_n,
    output logic            backlight_enable_pin_out,
    output logic            backlight_enable_pin_oe_n,
    output logic            panel_bias_enable_pin,
    output logic            hsync_out,
    output logic            hsync_oe_n,
    output logic            hsync_pulldown,
    output logic            vsync_out,
    output logic            vsync_oe_n,
    output logic            vsync_pulldown,
    output logic            display_float,
    output logic            memory_float,
    output logic      [3:0] test_function
);
    import spc_pkg::*;

    typedef struct packed {
        logic [7:0] pinfn;
        logic [7:0] pwrsig;
        logic [7:0] cswidth;
        logic [7:0] flt;
        logic [7:0] rdata;
        logic       hit;
        logic       act_out;
        logic       act_oe_n;
        logic       bkl_out;
        logic       bkl_oe_n;
        logic       bias;
        logic       hs;
        logic       hs_oe_n;
        logic       hs_pd;
        logic       vs;
        logic       vs_oe_n;
        logic       vs_pd;
        logic       dfloat;
        logic       mfloat;
        logic [3:0] test;
    } spc_state_t;

    spc_state_t cur;
    spc_state_t next_cur;
    logic       combined_sync_output;

    spc_combined_sync_output_gen #(
        .WIDTH_BITS (WIDTH_BITS)
    ) u_combined_sync_output (
        .clk         (clk),
        .rst_n       (rst_n),
        .crtc_hsync  (crtc_hsync),
        .crtc_vsync  (crtc_vsync),
        .pulse_width (cur.cswidth[WIDTH_BITS-1:0]),
        .round_off   (cur.cswidth[`SPC_CW_ROUND]),
        .combined_sync_output       (combined_sync_output)
    );

    // General pin: its function field applies only when the synthesizer
    // is on and the pin is not borrowed as an address line.
    function automatic logic [2:0] gp_pin(
        input logic [1:0] fn,
        input logic       active,
        input logic       native,
        input logic       data,
        input logic       cs
    );
        if (!active) begin
            return {native, 1'b0, 1'b0};
        end else if (spc_pin_fn_t'(fn) == SPC_FN_COMBINED_SYNC_OUTPUT) begin
            return {cs, 1'b0, 1'b0};
        end else if (spc_pin_fn_t'(fn) == SPC_FN_GPIN) begin
            return {1'b0, 1'b1, 1'b0};
        end else if (spc_pin_fn_t'(fn) == SPC_FN_GPOUT) begin
            return {data, 1'b0, 1'b0};
        end else begin
            return {native, 1'b0, 1'b0};
        end
    endfunction : gp_pin

    logic [2:0] act_res;
    logic [2:0] bkl_res;
    logic       h_func;
    logic       v_func;
    logic       sync_drive;

    always_comb begin
        next_cur = cur;
        if (reg_wr) begin
            if (reg_index == `SPC_IDX_PINFN) begin
                next_cur.pinfn = reg_wdata;
            end else if (reg_index == `SPC_IDX_PWRSIG) begin
                next_cur.pwrsig = reg_wdata;
            end else if (reg_index == `SPC_IDX_CSWIDTH) begin
                next_cur.cswidth = {2'b00, reg_wdata[5:0]};
            end else if (reg_index == `SPC_IDX_FLOAT) begin
                next_cur.flt = reg_wdata;
            end
        end
        next_cur.hit   = 1'b0;
        next_cur.rdata = 8'h00;
        if (reg_rd) begin
            next_cur.hit = 1'b1;
            if (reg_index == `SPC_IDX_PINFN) begin
                next_cur.rdata = {cur.pinfn[7:6], backlight_enable_pin_in, cur.pinfn[4:3],
                                  activity_indicator_pin_in, cur.pinfn[1:0]};
            end else if (reg_index == `SPC_IDX_PWRSIG) begin
                next_cur.rdata = cur.pwrsig;
            end else if (reg_index == `SPC_IDX_CSWIDTH) begin
                next_cur.rdata = cur.cswidth;
            end else if (reg_index == `SPC_IDX_FLOAT) begin
                next_cur.rdata = cur.flt;
            end else begin
                next_cur.hit = 1'b0;
            end
        end

        act_res = gp_pin(cur.pinfn[`SPC_PF_G0FN_LO +: 2], synth_enabled & ~act_pin_is_addr,
                         activity_level, cur.pinfn[`SPC_PF_G0DATA], combined_sync_output);
        bkl_res = gp_pin(cur.pinfn[`SPC_PF_G1FN_LO +: 2], synth_enabled & ~bkl_pin_is_addr,
                         backlight_level, cur.pinfn[`SPC_PF_G1DATA], combined_sync_output);
        next_cur.act_out  = act_res[2];
        next_cur.act_oe_n = act_res[1];
        next_cur.bkl_out  = bkl_res[2];
        next_cur.bkl_oe_n = bkl_res[1];

        next_cur.bias = cur.pinfn[`SPC_PF_BIASSEL] ? backlight_level : bias_enable_level;

        // Sync function choice: composite pair when the bit or the mode input asks for it
        h_func = (cur.pinfn[`SPC_PF_SYNCSEL] | combined_sync_output_mode) ? combined_sync_output : crtc_hsync;
        v_func = (cur.pinfn[`SPC_PF_SYNCSEL] | combined_sync_output_mode) ? crt_vsync_interval
                                                           : crtc_vsync;
        // Software levels give the monitor power states on the two sync pins
        if (cur.pwrsig[`SPC_PS_HSEL]) begin
            next_cur.hs = cur.pwrsig[`SPC_PS_HCLK] ? seq_clock : cur.pwrsig[`SPC_PS_HDATA];
        end else begin
            next_cur.hs = h_func;
        end
        if (cur.pwrsig[`SPC_PS_VSEL]) begin
            next_cur.vs = cur.pwrsig[`SPC_PS_VCLK] ? seq_clock : cur.pwrsig[`SPC_PS_VDATA];
        end else begin
            next_cur.vs = v_func;
        end

        // Relies on software having set a power-saving pattern first
        sync_drive = ~low_power_mode | cur.pwrsig[`SPC_PS_DRVSTBY];
        next_cur.hs_oe_n = ~sync_drive | cur.flt[`SPC_FT_BUS];
        next_cur.vs_oe_n = ~sync_drive | cur.flt[`SPC_FT_BUS];
        next_cur.hs_pd   = ~sync_drive;
        next_cur.vs_pd   = ~sync_drive;

        next_cur.dfloat = cur.flt[`SPC_FT_BUS];
        next_cur.mfloat = cur.flt[`SPC_FT_MEM];
        next_cur.test   = cur.flt[`SPC_FT_TESTEN] ? cur.flt[`SPC_FT_TEST_LO +: 4] : 4'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.pinfn    <= `SPC_RST_PINFN;
            cur.pwrsig   <= `SPC_RST_PWRSIG;
            cur.cswidth  <= `SPC_RST_CSWIDTH;
            cur.flt      <= `SPC_RST_FLOAT;
            cur.act_oe_n <= 1'b1;
            cur.bkl_oe_n <= 1'b1;
            cur.hs_oe_n  <= 1'b1;
            cur.vs_oe_n  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata                   = cur.rdata;
    assign reg_hit                     = cur.hit;
    assign activity_indicator_pin_out  = cur.act_out;
    assign activity_indicator_pin_oe_n = cur.act_oe_n;
    assign backlight_enable_pin_out    = cur.bkl_out;
    assign backlight_enable_pin_oe_n   = cur.bkl_oe_n;
    assign panel_bias_enable_pin       = cur.bias;
    assign hsync_out                   = cur.hs;
    assign hsync_oe_n                  = cur.hs_oe_n;
    assign hsync_pulldown              = cur.hs_pd;
    assign vsync_out                   = cur.vs;
    assign vsync_oe_n                  = cur.vs_oe_n;
    assign vsync_pulldown              = cur.vs_pd;
    assign display_float               = cur.dfloat;
    assign memory_float                = cur.mfloat;
    assign test_function               = cur.test;

    sequence s_pwr_h_data;
        cur.pwrsig[`SPC_PS_HSEL] && !cur.pwrsig[`SPC_PS_HCLK];
    endsequence
    sequence s_pwr_v_data;
        cur.pwrsig[`SPC_PS_VSEL] && !cur.pwrsig[`SPC_PS_VCLK];
    endsequence

    property p_sync_func;
        @(posedge clk) disable iff (!rst_n)
        (cur.pinfn[`SPC_PF_SYNCSEL] && !cur.pwrsig[`SPC_PS_VSEL])
            |=> vsync_out == $past(crt_vsync_interval);
    endproperty
    a_sync_func: assert property (p_sync_func) else $error("vsync not interval");

    property p_bias;
        @(posedge clk) disable iff (!rst_n)
        !cur.pinfn[`SPC_PF_BIASSEL] |=> panel_bias_enable_pin == $past(bias_enable_level);
    endproperty
    a_bias: assert property (p_bias) else $error("bias pin wrong source");

    property p_act_out;
        @(posedge clk) disable iff (!rst_n)
        (cur.pinfn[4:3] == 2'b11 && synth_enabled && !act_pin_is_addr)
            |=> (!activity_indicator_pin_oe_n && activity_indicator_pin_out == $past(cur.pinfn[2]));
    endproperty
    a_act_out: assert property (p_act_out) else $error("activity pin not driven");

    property p_act_in;
        @(posedge clk) disable iff (!rst_n)
        (cur.pinfn[4:3] == 2'b10 && synth_enabled && !act_pin_is_addr) |=> activity_indicator_pin_oe_n;
    endproperty
    a_act_in: assert property (p_act_in) else $error("activity input driven");

    property p_bkl_cs;
        @(posedge clk) disable iff (!rst_n)
        (cur.pinfn[7:6] == 2'b01 && synth_enabled && !bkl_pin_is_addr)
            |=> backlight_enable_pin_out == $past(combined_sync_output);
    endproperty
    a_bkl_cs: assert property (p_bkl_cs) else $error("backlight pin not combined_sync_output");

    property p_hs_data;
        @(posedge clk) disable iff (!rst_n)
        s_pwr_h_data |=> hsync_out == $past(cur.pwrsig[`SPC_PS_HDATA]);
    endproperty
    a_hs_data: assert property (p_hs_data) else $error("hsync data wrong");

    property p_vs_data;
        @(posedge clk) disable iff (!rst_n)
        s_pwr_v_data |=> vsync_out == $past(cur.pwrsig[`SPC_PS_VDATA]);
    endproperty
    a_vs_data: assert property (p_vs_data) else $error("vsync data wrong");

    property p_float_lp;
        @(posedge clk) disable iff (!rst_n)
        (low_power_mode && !cur.pwrsig[`SPC_PS_DRVSTBY]) |=> (hsync_oe_n && vsync_pulldown);
    endproperty
    a_float_lp: assert property (p_float_lp) else $error("sync not floated");

    property p_mem_float;
        @(posedge clk) disable iff (!rst_n)
        cur.flt[`SPC_FT_MEM] |=> memory_float;
    endproperty
    a_mem_float: assert property (p_mem_float) else $error("memory not floated");

    property p_test;
        @(posedge clk) disable iff (!rst_n)
        !cur.flt[`SPC_FT_TESTEN] |=> test_function == 4'h0;
    endproperty
    a_test: assert property (p_test) else $error("test bits active");
endmodule : spc_pin_control

// ---- testbench/spc_monitor_model.sv ----
`timescale 1ns/100ps
module spc_monitor_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       hsync_out,
    input  wire logic       hsync_oe_n,
    input  wire logic       hsync_pulldown,
    input  wire logic       vsync_out,
    input  wire logic       vsync_oe_n,
    input  wire logic       vsync_pulldown,
    output logic            hsync_line,
    output logic            vsync_line,
    output logic      [1:0] power_state
);
    logic       h_last, v_last, h_prev, v_prev;
    logic [6:0] h_idle, v_idle;
    // Floated line without pull-down: never trust it to keep its last value
    assign hsync_line = !hsync_oe_n ? hsync_out : (hsync_pulldown ? 1'b0 : ~h_last);
    assign vsync_line = !vsync_oe_n ? vsync_out : (vsync_pulldown ? 1'b0 : ~v_last);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {h_last, v_last, h_prev, v_prev} <= 4'h0;
            h_idle <= 7'h7F;
            v_idle <= 7'h7F;
        end else begin
            if (!hsync_oe_n) h_last <= hsync_out;
            if (!vsync_oe_n) v_last <= vsync_out;
            h_prev <= hsync_line;
            v_prev <= vsync_line;
            h_idle <= (hsync_line != h_prev) ? 7'h00 : h_idle + {6'h00, h_idle != 7'h7F};
            v_idle <= (vsync_line != v_prev) ? 7'h00 : v_idle + {6'h00, v_idle != 7'h7F};
        end
    end
    // A sync that has not moved for 64 cycles counts as inactive
    assign power_state = {v_idle >= 7'h40, h_idle >= 7'h40};
endmodule : spc_monitor_model

// ---- testbench/spc_pin_control_bench.sv ----
`timescale 1ns/100ps
module spc_pin_control_bench;
    logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cs_mode = 1'b0;
    logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       reg_hit, crtc_hsync = 1'b0, crtc_vsync = 1'b0, vs_int = 1'b0, seq_clk = 1'b1;
    logic       act_lvl = 1'b1, bias_lvl = 1'b1, bkl_lvl = 1'b1, synth = 1'b1, low_pwr = 1'b0;
    logic       act_ext = 1'b1, bkl_ext = 1'b0, toggle_en = 1'b0;
    logic       tg_h = 1'b0, tg_v = 1'b0, act_addr = 1'b0, bkl_addr = 1'b0;
    logic       act_out, act_oe_n, bkl_out, bkl_oe_n, bias_pin, hs_out, hs_oe_n, hs_pd;
    logic       vs_out, vs_oe_n, vs_pd, disp_fl, mem_fl, hs_line, vs_line;
    logic [3:0] test_fn, tcnt = 4'h0;
    logic [1:0] pstate;
    logic [7:0] ps_val [7] = '{8'h00, 8'h03, 8'h02, 8'h22, 8'h0C, 8'h08, 8'h48};
    logic [7:0] pm_val [4] = '{8'h00, 8'h02, 8'h08, 8'h0B};
    int         error_cnt = 0, checked = 0, n, m;
    wire        act_wire = act_oe_n ? act_ext : act_out;
    wire        bkl_wire = bkl_oe_n ? bkl_ext : bkl_out;

    spc_pin_control u_dut (.clk(clk), .rst_n(rst_n), .reg_index(reg_index),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .crtc_hsync(toggle_en ? tg_h : crtc_hsync),
        .crtc_vsync(toggle_en ? tg_v : crtc_vsync),
        .crt_vsync_interval(vs_int), .combined_sync_output_mode(cs_mode), .seq_clock(seq_clk),
        .activity_level(act_lvl), .bias_enable_level(bias_lvl), .backlight_level(bkl_lvl),
        .synth_enabled(synth), .act_pin_is_addr(act_addr), .bkl_pin_is_addr(bkl_addr),
        .low_power_mode(low_pwr), .activity_indicator_pin_in(act_wire),
        .backlight_enable_pin_in(bkl_wire), .activity_indicator_pin_out(act_out),
        .activity_indicator_pin_oe_n(act_oe_n), .backlight_enable_pin_out(bkl_out),
        .backlight_enable_pin_oe_n(bkl_oe_n), .panel_bias_enable_pin(bias_pin),
        .hsync_out(hs_out), .hsync_oe_n(hs_oe_n), .hsync_pulldown(hs_pd), .vsync_out(vs_out),
        .vsync_oe_n(vs_oe_n), .vsync_pulldown(vs_pd), .display_float(disp_fl),
        .memory_float(mem_fl), .test_function(test_fn));
    spc_monitor_model u_monitor (.clk(clk), .rst_n(rst_n), .hsync_out(hs_out),
        .hsync_oe_n(hs_oe_n), .hsync_pulldown(hs_pd), .vsync_out(vs_out),
        .vsync_oe_n(vs_oe_n), .vsync_pulldown(vs_pd), .hsync_line(hs_line),
        .vsync_line(vs_line), .power_state(pstate));

    always #50 clk = ~clk;
    // Free-running syncs so the monitor can judge activity
    always begin
        @(posedge clk);
        #10;
        if (toggle_en) begin
            tcnt++;
            tg_h = tcnt[0];
            tg_v = tcnt[2];
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask : tick
    // Leaves time for the register and the pin flop to follow
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        reg_index = idx;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(3);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] idx, input logic [7:0] exp, input logic hit);
        reg_index = idx;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check("rdata", reg_rdata, exp);
        check("hit", {7'h00, reg_hit}, {7'h00, hit});
        // Keeps a following read from raising the strobe in the same step
        tick(1);
    endtask : reg_read
    task automatic combined_sync_output_width(input logic [7:0] w, input logic vs, input int exp);
        reg_write(8'h7E, w);
        crtc_vsync = vs;
        tick(2);
        crtc_hsync = 1'b1;
        tick(1);
        crtc_hsync = 1'b0;
        n = 0;
        m = 0;
        repeat (40) begin
            tick(1);
            n += int'(hs_out === 1'b1);
            m += int'(act_out === 1'b1 && bkl_out === 1'b1);
        end
        check("combined_sync_output width", n[7:0], exp[7:0]);
        check("combined_sync_output on gp pins", m[7:0], exp[7:0]);
    endtask : combined_sync_output_width
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #3000000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(3);
        reg_read(8'h72, 8'h24, 1'b1);
        reg_read(8'h73, 8'h00, 1'b1);
        reg_read(8'h7E, 8'h00, 1'b1);
        reg_read(8'h7F, 8'h00, 1'b1);
        reg_read(8'h70, 8'h00, 1'b0);
        reg_write(8'h7E, 8'hFF);
        reg_read(8'h7E, 8'h3F, 1'b1);
        crtc_hsync = 1'b1;
        for (int i = 0; i < 7; i++) begin
            reg_write(8'h73, ps_val[i]);
            reg_read(8'h73, ps_val[i], 1'b1);
            check("hsync", {6'h00, hs_oe_n, hs_out}, {7'h00, 1'(7'b1111011 >> i)});
            check("vsync", {6'h00, vs_oe_n, vs_out}, {7'h00, 1'(7'b1010000 >> i)});
        end
        crtc_hsync = 1'b0;
        reg_write(8'h73, 8'h00);
        reg_write(8'h72, 8'h01);
        vs_int = 1'b1;
        tick(2);
        check("vsync interval", {7'h00, vs_out}, 8'h01);
        reg_write(8'h72, 8'h00);
        check("crt vsync", {7'h00, vs_out}, 8'h00);
        cs_mode = 1'b1;
        tick(2);
        check("vsync by mode", {7'h00, vs_out}, 8'h01);
        cs_mode = 1'b0;
        reg_write(8'h72, 8'h49);
        combined_sync_output_width(8'h04, 1'b0, 5);
        combined_sync_output_width(8'h1F, 1'b0, 32);
        combined_sync_output_width(8'h06, 1'b1, 4);
        combined_sync_output_width(8'h26, 1'b1, 3);
        crtc_vsync = 1'b0;
        for (int f = 0; f < 4; f++) begin
            reg_write(8'h72, {f[1:0], 1'b1, f[1:0], 1'b1, 2'b00});
            check("act pin", {6'h00, act_oe_n, act_wire}, {6'h00, f == 2, 1'(4'b1101 >> f)});
            check("bkl pin", {6'h00, bkl_oe_n, bkl_wire}, {6'h00, f == 2, 1'(4'b1001 >> f)});
            reg_read(8'h72, {f[1:0], 1'(4'b1001 >> f), f[1:0], 1'(4'b1101 >> f), 2'b00},
                     1'b1);
        end
        reg_write(8'h72, 8'hD8);
        check("gp out", {6'h00, act_wire, bkl_wire}, 8'h00);
        synth = 1'b0;
        tick(2);
        check("gated fn", {6'h00, act_wire, bkl_wire}, 8'h03);
        synth = 1'b1;
        act_addr = 1'b1;
        tick(2);
        check("act addr", {6'h00, act_wire, bkl_wire}, 8'h02);
        act_addr = 1'b0;
        bkl_addr = 1'b1;
        tick(2);
        check("bkl addr", {6'h00, act_wire, bkl_wire}, 8'h01);
        bkl_addr = 1'b0;
        reg_write(8'h72, 8'h00);
        bkl_lvl = 1'b0;
        tick(2);
        check("bias", {7'h00, bias_pin}, 8'h01);
        reg_write(8'h72, 8'h02);
        check("backlight", {7'h00, bias_pin}, 8'h00);
        bkl_lvl = 1'b1;
        reg_write(8'h72, 8'h00);
        toggle_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            reg_write(8'h73, pm_val[i]);
            tick(80);
            check("power state", {6'h00, pstate}, i[7:0]);
        end
        // Standby pattern first, then low power with sync kept driven
        reg_write(8'h73, 8'h12);
        low_pwr = 1'b1;
        tick(80);
        check("driven standby", {5'h00, hs_oe_n, pstate}, 8'h01);
        reg_write(8'h73, 8'h02);
        tick(80);
        check("floated", {2'b00, hs_oe_n, hs_pd, vs_oe_n, vs_pd, pstate}, 8'h3F);
        low_pwr = 1'b0;
        toggle_en = 1'b0;
        reg_write(8'h7F, 8'h01);
        check("float0", {4'h0, disp_fl, mem_fl, hs_oe_n, vs_oe_n}, 8'h0B);
        reg_write(8'h7F, 8'h02);
        check("float1", {4'h0, disp_fl, mem_fl, hs_oe_n, vs_oe_n}, 8'h04);
        reg_write(8'h7F, 8'h3C);
        check("test off", {4'h0, test_fn}, 8'h00);
        reg_write(8'h7F, 8'h7C);
        check("test on", {4'h0, test_fn}, 8'h0F);
        // Float bits left set so that the reset below has something to clear
        reg_write(8'h7F, 8'h47);
        check("test one", {4'h0, test_fn}, 8'h01);
        reg_read(8'h7F, 8'h47, 1'b1);
        rst_n = 1'b0;
        tick(2);
        check("float reset", {2'b00, disp_fl, mem_fl, test_fn}, 8'h00);
        rst_n = 1'b1;
        tick(3);
        reg_read(8'h7F, 8'h00, 1'b1);
        give_verdict();
    end
endmodule : spc_pin_control_bench
